// ===== rtl/cfv_pkg.sv
package cfv_pkg;

    localparam int PV_W = 26;
    localparam int RATE_W = 7;
    localparam int YEARS_W = 6;
    localparam int DIGIT_W = 7;
    localparam int NUM_DIGITS = 4;
    localparam int GROWTH_W = 8;
    localparam int VAL_W = 40;
    localparam int PROD_W = VAL_W + GROWTH_W;
    localparam int CONV_CNT_W = 2;

    localparam logic [GROWTH_W-1:0] GROWTH_BASE = 8'h64;
    localparam logic [PROD_W-1:0] SCALE_DIV = 48'h00_0000_0064;
    localparam logic [CONV_CNT_W-1:0] CONV_LAST = 2'h3;

    localparam logic [VAL_W-1:0] VAL_RST = 40'h00_0000_0000;
    localparam logic [YEARS_W-1:0] YEARS_RST = 6'h00;
    localparam logic [DIGIT_W-1:0] DIGIT_RST = 7'h00;

    typedef enum logic [2:0] {
        CFV_ST_INIT = 3'b000,
        CFV_ST_WAIT_LOW = 3'b001,
        CFV_ST_WAIT_HIGH = 3'b010,
        CFV_ST_CHECK = 3'b011,
        CFV_ST_STEP = 3'b100,
        CFV_ST_CONV = 3'b101,
        CFV_ST_HOLD = 3'b110
    } cfv_state_t;

    typedef struct packed {
        logic [PV_W-1:0] present_value_in;
        logic [RATE_W-1:0] rate;
        logic [YEARS_W-1:0] years;
    } cfv_operands_t;

    typedef struct packed {
        logic [DIGIT_W-1:0] result_digit_msd;
        logic [DIGIT_W-1:0] result_digit_second;
        logic [DIGIT_W-1:0] result_digit_third;
        logic [DIGIT_W-1:0] result_digit_lsd;
    } cfv_digits_t;

    typedef struct packed {
        cfv_state_t st;
        logic [VAL_W-1:0] value;
        logic [YEARS_W-1:0] years;
        logic [GROWTH_W-1:0] growth;
        logic [CONV_CNT_W-1:0] cnt;
        cfv_digits_t digits;
        logic done;
    } cfv_regs_t;

endpackage

// ===== rtl/cfv_engine.sv
// Functional notes
// - reset held high returns the state machine to its initial state
// - present value is 26-bit unsigned, from 0 up to 671088.63 currency
// - interest is a 7-bit whole percentage from 1 to 99
// - year count is 6-bit unsigned from 1 to 63
// - growth factor is interest plus 100, formed before iterating
// - while years remain, value becomes value times growth divided by 100
// - after each step years drop by one and are tested again
// - at zero years iteration stops and value goes to base-100 conversion
// - only integer part of scaled result is shown, smaller fraction cut
// - result appears as four separate base-100 display digits
`timescale 1ns/1ps
`default_nettype none

module cfv_engine (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_start,
    input wire cfv_pkg::cfv_operands_t i_operands,
    output cfv_pkg::cfv_digits_t o_digits,
    output logic o_done
);

    function automatic logic [cfv_pkg::PROD_W-1:0] cfv_div100(
        input logic [cfv_pkg::PROD_W-1:0] x
    );
        cfv_div100 = x / cfv_pkg::SCALE_DIV;
    endfunction

    cfv_pkg::cfv_regs_t r_r;
    cfv_pkg::cfv_regs_t r_nxt;

    logic [cfv_pkg::PROD_W-1:0] prod;
    logic [cfv_pkg::PROD_W-1:0] step_q;
    logic [cfv_pkg::PROD_W-1:0] conv_q;
    logic [cfv_pkg::PROD_W-1:0] conv_rem;

    // quotient only: the remainder of each step is dropped on purpose
    always_comb begin
        prod = {{cfv_pkg::GROWTH_W{1'b0}}, r_r.value} * {{cfv_pkg::VAL_W{1'b0}}, r_r.growth};
        step_q = cfv_div100(prod);
        conv_q = cfv_div100({{cfv_pkg::GROWTH_W{1'b0}}, r_r.value});
        conv_rem = {{cfv_pkg::GROWTH_W{1'b0}}, r_r.value} - conv_q * cfv_pkg::SCALE_DIV;
    end

    always_comb begin
        r_nxt = r_r;
        case (r_r.st)
            cfv_pkg::CFV_ST_INIT: begin
                r_nxt.done = 1'b0;
                r_nxt.st = cfv_pkg::CFV_ST_WAIT_LOW;
            end
            cfv_pkg::CFV_ST_WAIT_LOW: begin
                if (!i_start) begin
                    r_nxt.st = cfv_pkg::CFV_ST_WAIT_HIGH;
                end
            end
            cfv_pkg::CFV_ST_WAIT_HIGH: begin
                if (i_start) begin
                    // operands are taken as given; range checking sits elsewhere
                    r_nxt.value = {{(cfv_pkg::VAL_W - cfv_pkg::PV_W){1'b0}},
                                   i_operands.present_value_in};
                    r_nxt.years = i_operands.years;
                    r_nxt.growth = cfv_pkg::GROWTH_BASE
                                   + {1'b0, i_operands.rate};
                    r_nxt.st = cfv_pkg::CFV_ST_CHECK;
                end
            end
            cfv_pkg::CFV_ST_CHECK: begin
                r_nxt.cnt = '0;
                if (r_r.years != cfv_pkg::YEARS_RST) begin
                    r_nxt.st = cfv_pkg::CFV_ST_STEP;
                end else begin
                    r_nxt.st = cfv_pkg::CFV_ST_CONV;
                end
            end
            cfv_pkg::CFV_ST_STEP: begin
                // values past 40 bits wrap; legal operands can still exceed the display
                r_nxt.value = step_q[cfv_pkg::VAL_W-1:0];
                r_nxt.years = r_r.years - 6'h01;
                r_nxt.st = cfv_pkg::CFV_ST_CHECK;
            end
            cfv_pkg::CFV_ST_CONV: begin
                // peel one base-100 digit per cycle, least significant first
                r_nxt.value = conv_q[cfv_pkg::VAL_W-1:0];
                r_nxt.digits = {conv_rem[cfv_pkg::DIGIT_W-1:0],
                                r_r.digits.result_digit_msd,
                                r_r.digits.result_digit_second,
                                r_r.digits.result_digit_third};
                r_nxt.cnt = r_r.cnt + 2'h1;
                if (r_r.cnt == cfv_pkg::CONV_LAST) begin
                    r_nxt.done = 1'b1;
                    r_nxt.st = cfv_pkg::CFV_ST_HOLD;
                end
            end
            cfv_pkg::CFV_ST_HOLD: begin
                r_nxt.st = cfv_pkg::CFV_ST_HOLD;
            end
            default: begin
                r_nxt.st = cfv_pkg::CFV_ST_INIT;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_r.st <= cfv_pkg::CFV_ST_INIT;
            r_r.value <= cfv_pkg::VAL_RST;
            r_r.years <= cfv_pkg::YEARS_RST;
            r_r.growth <= cfv_pkg::GROWTH_BASE;
            r_r.cnt <= '0;
            r_r.digits <= {cfv_pkg::NUM_DIGITS{cfv_pkg::DIGIT_RST}};
            r_r.done <= 1'b0;
        end else if (i_ce) begin
            r_r <= r_nxt;
        end
    end

    assign o_digits = r_r.digits;
    assign o_done = r_r.done;

    sequence s_load;
        r_r.st == cfv_pkg::CFV_ST_WAIT_HIGH && i_start && i_ce;
    endsequence

    sequence s_step;
        r_r.st == cfv_pkg::CFV_ST_STEP && i_ce;
    endsequence

    sequence s_zero;
        r_r.st == cfv_pkg::CFV_ST_CHECK && r_r.years == cfv_pkg::YEARS_RST && i_ce;
    endsequence

    sequence s_conv;
        r_r.st == cfv_pkg::CFV_ST_CONV && i_ce;
    endsequence

    property p_reset_init;
        @(posedge i_mclk) i_rst |=> r_r.st == cfv_pkg::CFV_ST_INIT && !o_done;
    endproperty
    a_reset_init: assert property (p_reset_init)
        else $error("reset did not return to initial state");

    property p_wait_low;
        @(posedge i_mclk) disable iff (i_rst)
        r_r.st == cfv_pkg::CFV_ST_WAIT_LOW && i_start |=> r_r.st == cfv_pkg::CFV_ST_WAIT_LOW;
    endproperty
    a_wait_low: assert property (p_wait_low)
        else $error("left start-low wait while start high");

    property p_growth;
        @(posedge i_mclk) disable iff (i_rst)
        s_load |=> r_r.growth == 8'(cfv_pkg::GROWTH_BASE + $past(i_operands.rate));
    endproperty
    a_growth: assert property (p_growth)
        else $error("growth factor is not rate plus 100");

    property p_load;
        @(posedge i_mclk) disable iff (i_rst)
        s_load |=> r_r.years == $past(i_operands.years)
            && r_r.value[cfv_pkg::PV_W-1:0] == $past(i_operands.present_value_in)
            && r_r.st == cfv_pkg::CFV_ST_CHECK;
    endproperty
    a_load: assert property (p_load)
        else $error("operands not loaded on start");

    property p_step_grows;
        @(posedge i_mclk) disable iff (i_rst)
        s_step ##0 (r_r.value < 40'h00_0100_0000) |=> r_r.value >= $past(r_r.value)
            && r_r.value <= 40'(($past(r_r.value) * 2));
    endproperty
    a_step_grows: assert property (p_step_grows)
        else $error("step result outside value to twice value");

    property p_step_count;
        @(posedge i_mclk) disable iff (i_rst)
        s_step |=> r_r.years == 6'($past(r_r.years) - 6'h01) && r_r.st == cfv_pkg::CFV_ST_CHECK;
    endproperty
    a_step_count: assert property (p_step_count)
        else $error("year count not decremented after step");

    property p_zero_stop;
        @(posedge i_mclk) disable iff (i_rst)
        r_r.st == cfv_pkg::CFV_ST_CHECK && r_r.years == cfv_pkg::YEARS_RST && i_ce
            |=> r_r.st == cfv_pkg::CFV_ST_CONV;
    endproperty
    a_zero_stop: assert property (p_zero_stop)
        else $error("did not stop iterating at zero years");

    property p_digits_legal;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(o_done) |-> o_digits.result_digit_msd < 7'h64
            && o_digits.result_digit_second < 7'h64
            && o_digits.result_digit_third < 7'h64
            && o_digits.result_digit_lsd < 7'h64;
    endproperty
    a_digits_legal: assert property (p_digits_legal)
        else $error("display digit out of base-100 range");

    property p_hold;
        @(posedge i_mclk) disable iff (i_rst)
        o_done |=> o_done && $stable(o_digits);
    endproperty
    a_hold: assert property (p_hold)
        else $error("final digits changed before reset");

    property p_reset_clear;
        @(posedge i_mclk) i_rst |=> o_digits == '0 && r_r.years == cfv_pkg::YEARS_RST
            && r_r.cnt == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset did not clear digits and count");

    property p_init_exit;
        @(posedge i_mclk) disable iff (i_rst)
        r_r.st == cfv_pkg::CFV_ST_INIT && i_ce
            |=> r_r.st == cfv_pkg::CFV_ST_WAIT_LOW && !o_done;
    endproperty
    a_init_exit: assert property (p_init_exit)
        else $error("initial state did not move to start-low wait");

    property p_low_seen;
        @(posedge i_mclk) disable iff (i_rst)
        r_r.st == cfv_pkg::CFV_ST_WAIT_LOW && !i_start && i_ce
            |=> r_r.st == cfv_pkg::CFV_ST_WAIT_HIGH;
    endproperty
    a_low_seen: assert property (p_low_seen)
        else $error("start seen low but wait did not advance");

    property p_high_wait;
        @(posedge i_mclk) disable iff (i_rst)
        r_r.st == cfv_pkg::CFV_ST_WAIT_HIGH && !i_start
            |=> r_r.st == cfv_pkg::CFV_ST_WAIT_HIGH && r_r.years == $past(r_r.years);
    endproperty
    a_high_wait: assert property (p_high_wait)
        else $error("operands taken before start went high");

    property p_growth_kept;
        @(posedge i_mclk) disable iff (i_rst)
        (r_r.st == cfv_pkg::CFV_ST_CHECK || r_r.st == cfv_pkg::CFV_ST_STEP)
            |=> r_r.growth == $past(r_r.growth);
    endproperty
    a_growth_kept: assert property (p_growth_kept)
        else $error("growth factor changed while iterating");

    property p_check_step;
        @(posedge i_mclk) disable iff (i_rst)
        r_r.st == cfv_pkg::CFV_ST_CHECK && r_r.years != cfv_pkg::YEARS_RST && i_ce
            |=> r_r.st == cfv_pkg::CFV_ST_STEP && r_r.years == $past(r_r.years)
            && r_r.value == $past(r_r.value);
    endproperty
    a_check_step: assert property (p_check_step)
        else $error("nonzero year count did not lead to a step");

    property p_step_exact;
        @(posedge i_mclk) disable iff (i_rst)
        s_step ##0 (r_r.value < 40'h00_0100_0000)
            |=> {8'h00, r_r.value} == ({8'h00, $past(r_r.value)}
            * {40'h00_0000_0000, $past(r_r.growth)}) / cfv_pkg::SCALE_DIV;
    endproperty
    a_step_exact: assert property (p_step_exact)
        else $error("step is not value times growth over 100");

    property p_conv_digit;
        @(posedge i_mclk) disable iff (i_rst)
        s_conv |=> r_r.digits.result_digit_msd == 7'({8'h00, $past(r_r.value)} % cfv_pkg::SCALE_DIV)
            && {8'h00, r_r.value} == {8'h00, $past(r_r.value)} / cfv_pkg::SCALE_DIV;
    endproperty
    a_conv_digit: assert property (p_conv_digit)
        else $error("converted digit is not the integer remainder");

    property p_conv_shift;
        @(posedge i_mclk) disable iff (i_rst)
        s_conv |=> r_r.digits.result_digit_second == $past(r_r.digits.result_digit_msd)
            && r_r.digits.result_digit_third == $past(r_r.digits.result_digit_second)
            && r_r.digits.result_digit_lsd == $past(r_r.digits.result_digit_third);
    endproperty
    a_conv_shift: assert property (p_conv_shift)
        else $error("digit slots did not shift during conversion");

    property p_conv_length;
        @(posedge i_mclk) disable iff (i_rst)
        s_zero ##1 s_conv [*4] |=> o_done && r_r.st == cfv_pkg::CFV_ST_HOLD;
    endproperty
    a_conv_length: assert property (p_conv_length)
        else $error("conversion did not end after four digits");

    property p_conv_years;
        @(posedge i_mclk) disable iff (i_rst)
        r_r.st == cfv_pkg::CFV_ST_CONV |-> r_r.years == cfv_pkg::YEARS_RST;
    endproperty
    a_conv_years: assert property (p_conv_years)
        else $error("conversion entered with years remaining");

    property p_done_source;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(o_done) |-> $past(r_r.st) == cfv_pkg::CFV_ST_CONV
            && r_r.st == cfv_pkg::CFV_ST_HOLD;
    endproperty
    a_done_source: assert property (p_done_source)
        else $error("done raised outside conversion");

    property p_freeze;
        @(posedge i_mclk) disable iff (i_rst)
        !i_ce |=> $stable(r_r);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    property p_digits_idle;
        @(posedge i_mclk) disable iff (i_rst)
        (r_r.st == cfv_pkg::CFV_ST_CHECK || r_r.st == cfv_pkg::CFV_ST_STEP)
            |-> o_digits == '0;
    endproperty
    a_digits_idle: assert property (p_digits_idle)
        else $error("digits changed before conversion");

endmodule

`default_nettype wire

// ===== tb/cfv_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module cfv_ctrl_model (
    input wire logic i_mclk,
    input wire logic i_go,
    input wire cfv_pkg::cfv_operands_t i_ops,
    output logic o_start,
    output cfv_pkg::cfv_operands_t o_operands
);
    initial begin
        o_start = 1'b1;
        o_operands = '0;
        forever begin
            @(posedge i_go);
            @(posedge i_mclk);
            #2 o_start = 1'b0;
            repeat (3) @(posedge i_mclk);
            // operands are range-limited and pre-scaled by the caller
            #2 o_operands = i_ops;
            o_start = 1'b1;
            @(posedge i_mclk);
            // lines invert after the take so a design that resamples is caught
            #2 o_operands = ~i_ops;
        end
    end
endmodule

`default_nettype wire

// ===== tb/cfv_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none

module cfv_engine_tb;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic go = 1'b0;
    logic start;
    cfv_pkg::cfv_operands_t ops = '0;
    cfv_pkg::cfv_operands_t ops_bus;
    cfv_pkg::cfv_digits_t digits;
    cfv_pkg::cfv_digits_t held;
    logic done;
    int error_cnt = 0;
    int n_tests = 0;

    initial begin
        forever #25 i_mclk = ~i_mclk;
    end

    cfv_ctrl_model u_ctrl (.i_mclk(i_mclk), .i_go(go), .i_ops(ops),
        .o_start(start), .o_operands(ops_bus));

    cfv_engine u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_start(start),
        .i_operands(ops_bus), .o_digits(digits), .o_done(done));

    task automatic reset_dut();
        @(posedge i_mclk);
        #2 i_rst = 1'b1;
        repeat (5) @(posedge i_mclk);
        #1;
        n_tests++;
        if (done !== 1'b0 || digits !== '0) begin
            error_cnt++;
            $display("[ERR] %0t outputs not cleared in reset", $time);
        end
        #1 i_rst = 1'b0;
    endtask

    function automatic cfv_pkg::cfv_digits_t expect_digits(longint pv, longint r, int n);
        longint v;
        v = pv;
        for (int i = 0; i < n; i++) begin
            v = v * (100 + r) / 100;
        end
        v = v % 100000000;
        return {7'(v / 1000000), 7'(v / 10000 % 100), 7'(v / 100 % 100), 7'(v % 100)};
    endfunction

    task automatic run_case(input int pv, input int r, input int n, input int freeze);
        cfv_pkg::cfv_digits_t exp_d;
        exp_d = expect_digits(pv, r, n);
        reset_dut();
        ops = {26'(pv), 7'(r), 6'(n)};
        go = 1'b1;
        @(posedge start);
        #1 go = 1'b0;
        @(posedge i_mclk);
        #2 i_ce = (freeze == 0);
        repeat (freeze) @(posedge i_mclk);
        #2 i_ce = 1'b1;
        // done lands 2n+5 enabled edges after the take edge; look one edge before it
        repeat (2 * n + 4) @(posedge i_mclk);
        #1;
        n_tests++;
        if (done !== 1'b0) begin
            error_cnt++;
            $display("[ERR] %0t done too early", $time);
        end
        @(posedge i_mclk);
        #1;
        n_tests++;
        if (done !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t done missing", $time);
        end
        n_tests++;
        if (digits !== exp_d) begin
            error_cnt++;
            $display("[ERR] %0t wrong result digits %h expected %h", $time, digits, exp_d);
        end
        repeat (12) @(posedge i_mclk);
        #1;
        n_tests++;
        if (done !== 1'b1 || digits !== exp_d) begin
            error_cnt++;
            $display("[ERR] %0t result not held", $time);
        end
    endtask

    task automatic reset_mid_run();
        reset_dut();
        ops = {26'(5000), 7'(20), 6'(63)};
        go = 1'b1;
        @(posedge start);
        #1 go = 1'b0;
        repeat (20) @(posedge i_mclk);
        reset_dut();
        // start stays high, so no new calculation may begin
        repeat (200) @(posedge i_mclk);
        #1;
        n_tests++;
        if (done !== 1'b0 || digits !== '0) begin
            error_cnt++;
            $display("[ERR] %0t ran without start low", $time);
        end
    endtask

    task automatic print_verdict();
        $display("errors %0d, checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        run_case(10000, 10, 5, 0);
        run_case(1000, 15, 3, 2);
        run_case(67108863, 1, 1, 0);
        run_case(100, 1, 63, 0);
        run_case(500, 99, 2, 0);
        reset_mid_run();
        print_verdict();
    end
endmodule

`default_nettype wire
